// File: hw/ioxp_device.sv
// Functional notes
// - interrupt on any edge of input pins
// - clear on return to level or read
// - read clear at ack bit rising edge
// - changes after clearing signal again
// - output pins never interrupt
// - output-to-input switch may interrupt falsely
// - master starts only on idle bus
// - write: start, address, command byte
// - written bytes alternate within register pair
// - unlimited bytes per write transfer
// - read: command write, restart, address read
// - capture write at ack clock rising edge
// - read bytes alternate within pair, unlimited
// - master nacks last byte read
// - pointer keeps partner of last read
// - reset initialises registers and bus machine
// - command low bits select register
// - reset: outputs, directions ones, polarity zeros
// - direction one input, zero driven output
// - polarity bit inverts input value
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module ioxp_device
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // serial bus
    ioxp_if.slave bus,
    // address straps
    input wire logic [2:0] addrPins,
    // port pins
    input wire logic [ioxp_pkg::PIN_W-1:0] pinIn,
    output logic [ioxp_pkg::PIN_W-1:0] pinOut,
    output logic [ioxp_pkg::PIN_W-1:0] pinOe
);
    import ioxp_pkg::*;

    typedef enum logic [2:0] {IDLE, ADDR, CMD, WR, RD} ioxp_mode_type;

    typedef struct packed {
        logic [1:0] sclS;
        logic [1:0] sdaS;
        logic sclP;
        logic sdaP;
        logic [PIN_W-1:0] pin1;
        logic [PIN_W-1:0] pin2;
        logic [2:0] adr1;
        logic [2:0] adr2;
        ioxp_mode_type mode;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [2:0] ptr;
        logic [PIN_W-1:0] outR;
        logic [PIN_W-1:0] polR;
        logic [PIN_W-1:0] cfgR;
        logic [PIN_W-1:0] snap;
        logic snapLoad;
        logic sdaOe;
        logic intOe;
        logic [PIN_W-1:0] pinO;
        logic [PIN_W-1:0] pinE;
    } ioxp_state_type;

    ioxp_state_type q;
    ioxp_state_type n;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic startSeen;
    logic stopSeen;
    logic [PIN_W-1:0] inVal;
    logic [PIN_W-1:0] pend;

    function automatic logic [7:0] regRead(input logic [2:0] p, input logic [PIN_W-1:0] inv,
                                           input logic [PIN_W-1:0] outv, input logic [PIN_W-1:0] polv,
                                           input logic [PIN_W-1:0] cfgv);
        logic [PIN_W-1:0] w;
        w = inv;
        unique case (p[2:1])
            PAIR_IN: w = inv;
            PAIR_OUT: w = outv;
            PAIR_POL: w = polv;
            PAIR_CFG: w = cfgv;
        endcase
        return p[0] ? w[PIN_W-1:PORT_W] : w[PORT_W-1:0];
    endfunction

    assign scl = q.sclS[1];
    assign sda = q.sdaS[1];
    assign rise = ~q.sclP & scl;
    assign fall = q.sclP & ~scl;
    assign startSeen = scl & q.sclP & q.sdaP & ~sda;
    assign stopSeen = scl & q.sclP & ~q.sdaP & sda;
    assign inVal = q.pin2 ^ q.polR;
    // only pins set as inputs can flag a difference from the snapshot
    assign pend = q.cfgR & (inVal ^ q.snap);

    always_comb
    begin
        n = q;
        n.sclS = {q.sclS[0], bus.sclLine};
        n.sdaS = {q.sdaS[0], bus.sdaLine};
        n.sclP = scl;
        n.sdaP = sda;
        n.pin1 = pinIn;
        n.pin2 = q.pin1;
        n.adr1 = addrPins;
        n.adr2 = q.adr1;
        // first snapshot after reset follows the pins
        if (q.snapLoad)
        begin
            n.snap = inVal;
            n.snapLoad = 1'b0;
        end
        if (startSeen)
        begin
            n.mode = ADDR;
            n.cnt = 4'h0;
            n.sdaOe = 1'b0;
        end
        else if (stopSeen)
        begin
            n.mode = IDLE;
            n.sdaOe = 1'b0;
        end
        else if (q.mode != IDLE)
        begin
            if (rise)
            begin
                if (q.cnt < ACK_SLOT)
                begin
                    n.sh = {q.sh[6:0], sda};
                    n.cnt = 4'(q.cnt + 4'h1);
                end
                else
                begin
                    n.cnt = 4'h0;
                    unique case (q.mode)
                        ADDR:
                        begin
                            n.mode = q.sh[0] ? RD : CMD;
                            n.tx = regRead(q.ptr, inVal, q.outR, q.polR, q.cfgR);
                        end
                        CMD:
                        begin
                            n.ptr = q.sh[2:0];
                            n.mode = WR;
                        end
                        WR:
                        begin
                            // input pair is read only
                            unique case (q.ptr[2:1])
                                PAIR_OUT: n.outR[{q.ptr[0], 3'h0} +: PORT_W] = q.sh;
                                PAIR_POL: n.polR[{q.ptr[0], 3'h0} +: PORT_W] = q.sh;
                                PAIR_CFG: n.cfgR[{q.ptr[0], 3'h0} +: PORT_W] = q.sh;
                                PAIR_IN: n.ptr = q.ptr;
                            endcase
                            n.ptr = q.ptr ^ 3'h1;
                        end
                        RD:
                        begin
                            if (q.ptr[2:1] == PAIR_IN)
                            begin
                                // reading an input port re-arms its snapshot
                                n.snap[{q.ptr[0], 3'h0} +: PORT_W] = inVal[{q.ptr[0], 3'h0} +: PORT_W];
                            end
                            n.ptr = q.ptr ^ 3'h1;
                            if (!sda)
                                n.tx = regRead(q.ptr ^ 3'h1, inVal, q.outR, q.polR, q.cfgR);
                            else
                                n.mode = IDLE;
                        end
                        IDLE:
                            n.mode = IDLE;
                    endcase
                end
            end
            else if (fall)
            begin
                if (q.mode == RD && q.cnt < ACK_SLOT)
                begin
                    n.sdaOe = ~q.tx[7];
                    n.tx = {q.tx[6:0], 1'b0};
                end
                else if (q.cnt == ACK_SLOT && q.mode != RD)
                begin
                    if (q.mode == ADDR && q.sh[7:1] != {ADDR_BASE, q.adr2})
                    begin
                        n.mode = IDLE;
                        n.sdaOe = 1'b0;
                    end
                    else
                        n.sdaOe = 1'b1;
                end
                else
                    n.sdaOe = 1'b0;
            end
        end
        // the snapshot is not valid until its first load after reset
        n.intOe = |pend & ~q.snapLoad;
        n.pinO = n.outR;
        n.pinE = ~n.cfgR;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.sclS <= 2'h3;
            q.sdaS <= 2'h3;
            q.sclP <= 1'b1;
            q.sdaP <= 1'b1;
            q.mode <= IDLE;
            q.outR <= {2{OUT_RST}};
            q.polR <= {2{POL_RST}};
            q.cfgR <= {2{CFG_RST}};
            q.snapLoad <= 1'b1;
            // pin synchroniser keeps running so the first snapshot sees real levels
            q.pin1 <= pinIn;
            q.pin2 <= q.pin1;
            q.pinO <= {2{OUT_RST}};
            q.pinE <= ~{2{CFG_RST}};
        end
        else
            q <= n;
    end

    assign bus.sdaOutS = 1'b0;
    assign bus.sdaOeS = q.sdaOe;
    assign bus.intOutS = 1'b0;
    assign bus.intOeS = q.intOe;
    assign pinOut = q.pinO;
    assign pinOe = q.pinE;
endmodule

// File: hw/ioxp_pkg.sv
package ioxp_pkg;
    // port geometry
    localparam int PORT_W = 8;
    localparam int PIN_W = 2 * PORT_W;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // register selection: bits [2:1] pick the pair, bit 0 the port
    localparam logic [1:0] PAIR_IN = 2'h0;
    localparam logic [1:0] PAIR_OUT = 2'h1;
    localparam logic [1:0] PAIR_POL = 2'h2;
    localparam logic [1:0] PAIR_CFG = 2'h3;

    // reset values of one port byte
    localparam logic [7:0] OUT_RST = 8'hff;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'hff;

    // upper slave address bits, low three come from the straps
    localparam logic [3:0] ADDR_BASE = 4'h4;

    // serial clock timing of the controller
    localparam int CLK_KHZ = 125000;
    localparam int SCL_KHZ = 400;
    localparam int QTR_CYC = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
    localparam int QTR_W = $clog2(QTR_CYC + 1);

    // controller register port
    localparam logic [1:0] HREG_CTRL = 2'h0;
    localparam logic [1:0] HREG_TX = 2'h1;
    localparam logic [1:0] HREG_RX = 2'h2;
    localparam logic [1:0] HREG_STAT = 2'h3;
    localparam int CTRL_RD_BIT = 3;
    localparam int CTRL_TWO_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    localparam int STAT_INT_BIT = 2;
endpackage

// File: hw/ioxp_if.sv
`timescale 1ns/1ps
interface ioxp_if;
    logic sclOutM;
    logic sclOeM;
    logic sdaOutM;
    logic sdaOeM;
    logic sdaOutS;
    logic sdaOeS;
    logic intOutS;
    logic intOeS;
    logic sclLine;
    logic sdaLine;
    logic intLine;

    // open-drain wires with pull-ups
    assign sclLine = ~(sclOeM & ~sclOutM);
    assign sdaLine = ~((sdaOeM & ~sdaOutM) | (sdaOeS & ~sdaOutS));
    assign intLine = ~(intOeS & ~intOutS);

    modport master (output sclOutM, sclOeM, sdaOutM, sdaOeM, input sclLine, sdaLine, intLine);
    modport slave (output sdaOutS, sdaOeS, intOutS, intOeS, input sclLine, sdaLine);
endinterface

// File: hw/ioxp_host.sv
`timescale 1ns/1ps
module ioxp_host
#(
    parameter logic [6:0] DEV_ADDR = {ioxp_pkg::ADDR_BASE, 3'h0}
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // serial bus
    ioxp_if.master bus,
    // register port
    input wire logic [1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata
);
    import ioxp_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} ioxp_phase_type;
    typedef enum logic [2:0] {K_START1, K_ADDRW, K_CMD, K_START2, K_ADDRR, K_DATA} ioxp_step_type;

    typedef struct packed {
        logic [1:0] sdaS;
        logic [1:0] intS;
        ioxp_phase_type phase;
        ioxp_step_type step;
        logic [QTR_W-1:0] tick;
        logic [1:0] qtr;
        logic [3:0] bitCnt;
        logic [8:0] sh;
        logic [8:0] rsh;
        logic rd;
        logic two;
        logic [2:0] sel;
        logic idx;
        logic [15:0] tx;
        logic [15:0] rx;
        logic busy;
        logic nack;
        logic sclOe;
        logic sdaOe;
        logic [15:0] rdata;
    } ioxp_hstate_type;

    ioxp_hstate_type q;
    ioxp_hstate_type n;
    logic [8:0] rshNext;

    assign rshNext = {q.rsh[7:0], q.sdaS[1]};

    always_comb
    begin
        n = q;
        n.sdaS = {q.sdaS[0], bus.sdaLine};
        n.intS = {q.intS[0], bus.intLine};
        n.rdata = 16'h0000;
        if (regRd)
        begin
            unique case (regAddr)
                HREG_RX: n.rdata = q.rx;
                HREG_STAT: n.rdata = {13'h0000, ~q.intS[1], q.nack, q.busy};
                HREG_TX: n.rdata = q.tx;
                HREG_CTRL: n.rdata = {11'h000, q.two, q.rd, q.sel};
            endcase
        end
        if (regWr && regAddr == HREG_TX)
            n.tx = regWdata;
        // a start order while busy is ignored
        if (regWr && regAddr == HREG_CTRL && !q.busy)
        begin
            n.sel = regWdata[2:0];
            n.rd = regWdata[CTRL_RD_BIT];
            n.two = regWdata[CTRL_TWO_BIT];
            n.busy = 1'b1;
            n.nack = 1'b0;
            n.idx = 1'b0;
            n.step = K_START1;
            n.phase = H_START;
            n.qtr = 2'h0;
            n.tick = '0;
        end
        else if (q.phase != H_IDLE)
        begin
            if (q.tick != QTR_W'(QTR_CYC - 1))
                n.tick = QTR_W'(q.tick + 1'b1);
            else
            begin
                n.tick = '0;
                n.qtr = 2'(q.qtr + 2'h1);
                unique case (q.phase)
                    H_START:
                        unique case (q.qtr)
                            2'h0: n.sdaOe = 1'b0;
                            2'h1: n.sclOe = 1'b0;
                            2'h2: n.sdaOe = 1'b1;
                            2'h3:
                            begin
                                n.sclOe = 1'b1;
                                n.phase = H_BIT;
                                n.bitCnt = 4'h0;
                                n.step = (q.step == K_START1) ? K_ADDRW : K_ADDRR;
                                n.sh = {DEV_ADDR, q.step != K_START1, 1'b1};
                            end
                        endcase
                    H_BIT:
                        unique case (q.qtr)
                            2'h0: n.sdaOe = ~q.sh[8];
                            2'h1: n.sclOe = 1'b0;
                            2'h2: n.rsh = rshNext;
                            2'h3:
                            begin
                                n.sclOe = 1'b1;
                                n.sh = {q.sh[7:0], 1'b1};
                                n.bitCnt = 4'(q.bitCnt + 4'h1);
                                if (q.bitCnt == ACK_SLOT)
                                begin
                                    n.bitCnt = 4'h0;
                                    n.phase = H_STOP;
                                    if (q.rsh[0] && !(q.step == K_DATA && q.rd))
                                        n.nack = 1'b1;
                                    else
                                        unique case (q.step)
                                            K_ADDRW:
                                            begin
                                                n.phase = H_BIT;
                                                n.step = K_CMD;
                                                n.sh = {5'h00, q.sel, 1'b1};
                                            end
                                            K_CMD:
                                            begin
                                                n.phase = q.rd ? H_START : H_BIT;
                                                n.step = q.rd ? K_START2 : K_DATA;
                                                n.sh = {q.tx[7:0], 1'b1};
                                            end
                                            K_ADDRR:
                                            begin
                                                n.phase = H_BIT;
                                                n.step = K_DATA;
                                                n.sh = {8'hff, ~q.two};
                                            end
                                            K_DATA:
                                            begin
                                                if (q.rd)
                                                    n.rx[{q.idx, 3'h0} +: PORT_W] = q.rsh[8:1];
                                                if (q.two && !q.idx)
                                                begin
                                                    n.idx = 1'b1;
                                                    n.phase = H_BIT;
                                                    n.sh = q.rd ? 9'h1ff : {q.tx[15:8], 1'b1};
                                                end
                                            end
                                            default:
                                                n.phase = H_STOP;
                                        endcase
                                end
                            end
                        endcase
                    H_STOP:
                        unique case (q.qtr)
                            2'h0: n.sdaOe = 1'b1;
                            2'h1: n.sclOe = 1'b0;
                            2'h2: n.sdaOe = 1'b0;
                            2'h3:
                            begin
                                n.phase = H_IDLE;
                                n.busy = 1'b0;
                            end
                        endcase
                    H_IDLE:
                        n.phase = H_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.sdaS <= 2'h3;
            q.intS <= 2'h3;
            q.phase <= H_IDLE;
            q.step <= K_START1;
        end
        else
            q <= n;
    end

    assign bus.sclOutM = 1'b0;
    assign bus.sclOeM = q.sclOe;
    assign bus.sdaOutM = 1'b0;
    assign bus.sdaOeM = q.sdaOe;
    assign regRdata = q.rdata;
endmodule

// File: verification/ioxp_sva.sv
`timescale 1ns/1ps
module ioxp_sva
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // serial bus
    input wire logic sclOeM,
    input wire logic sdaOeM,
    input wire logic sdaOeS,
    input wire logic intOeS,
    input wire logic sclLine,
    input wire logic sdaLine,
    input wire logic intLine
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence startCond;
        sclLine && $fell(sdaLine);
    endsequence

    sequence slaveTakesSda;
        $rose(sdaOeS);
    endsequence

    AST_INT_WIRE: assert property (intLine == !intOeS)
        else $error("interrupt line does not follow the device pull-down");
    AST_SLAVE_SDA_SCL_LOW: assert property ($changed(sdaOeS) |-> !sclLine)
        else $error("device moved SDA while SCL high");
    AST_SLAVE_SDA_HOLD: assert property (slaveTakesSda |-> sdaOeS [*8])
        else $error("device SDA pull-down too short");
    AST_START_FROM_HIGH: assert property (startCond |-> $past(sclLine, 8))
        else $error("start without SCL high beforehand");
    AST_START_BY_MASTER: assert property (startCond |-> sdaOeM && !sdaOeS && !sclOeM)
        else $error("start not made by the master");
    AST_SCL_HIGH_MIN: assert property ($rose(sclLine) |-> sclLine [*8])
        else $error("SCL high phase too short");
    AST_SCL_LOW_MIN: assert property ($fell(sclLine) |-> !sclLine [*8])
        else $error("SCL low phase too short");
    AST_IDLE_AFTER_RESET: assert property ($rose(reset_n) |-> !sdaOeS && !intOeS && sclLine && sdaLine)
        else $error("bus not idle after reset");
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
    import ioxp_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata;
    logic [PIN_W-1:0] extPins = 16'ha5c3;
    logic [PIN_W-1:0] pinLevel;
    logic [PIN_W-1:0] pinOut;
    logic [PIN_W-1:0] pinOe;
    logic [15:0] rx;
    int bad_count = 0;
    int check_count = 0;

    ioxp_if busIf();

    always #4 clk_sys = ~clk_sys;

    // driven outputs win over the external drivers
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extPins);

    ioxp_device ioxp_device_inst(.clk_sys(clk_sys), .reset_n(reset_n), .bus(busIf.slave), .addrPins(3'h0),
        .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe));
    ioxp_host ioxp_host_inst(.clk_sys(clk_sys), .reset_n(reset_n), .bus(busIf.master), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
    ioxp_sva ioxp_sva_inst(.clk_sys(clk_sys), .reset_n(reset_n), .sclOeM(busIf.sclOeM), .sdaOeM(busIf.sdaOeM),
        .sdaOeS(busIf.sdaOeS), .intOeS(busIf.intOeS), .sclLine(busIf.sclLine), .sdaLine(busIf.sdaLine),
        .intLine(busIf.intLine));

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // one serial transfer: load data, start, poll until idle
    task xfer(input logic [4:0] ctrl, input logic [15:0] tx);
        logic [15:0] s;
        int n;
        wr(HREG_TX, tx);
        wr(HREG_CTRL, {11'h000, ctrl});
        repeat (4) @(posedge clk_sys);
        s = 16'h0001;
        n = 0;
        while (s[STAT_BUSY_BIT] !== 1'b0 && n < 20000)
        begin
            rd(HREG_STAT, s);
            n++;
        end
        chk({14'h0000, s[STAT_NACK_BIT], s[STAT_BUSY_BIT]}, 16'h0000);
    endtask

    task intChk(input logic e);
        logic [15:0] s;
        repeat (12) @(posedge clk_sys);
        rd(HREG_STAT, s);
        chk({15'h0000, s[STAT_INT_BIT]}, {15'h0000, e});
    endtask

    task flip;
        @(posedge clk_sys);
        extPins <= extPins ^ 16'h0010;
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial
    begin
        repeat (96000) @(posedge clk_sys);
        bad_count++;
        test_done();
    end

    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(pinOut, {OUT_RST, OUT_RST});
        chk(pinOe, ~{CFG_RST, CFG_RST});
        // start in output port 1, second byte lands in port 0
        xfer(5'h13, 16'h963c);
        chk(pinOut, 16'h3c96);
        rd(HREG_CTRL, rx);
        chk(rx, 16'h0013);
        rd(HREG_TX, rx);
        chk(rx, 16'h963c);
        xfer(5'h17, 16'hf00f);
        chk(pinOe, 16'hf00f);
        // configuration pair read back, port 1 first
        xfer(5'h1f, 16'h0000);
        rd(HREG_RX, rx);
        chk(rx, 16'hf00f);
        // output pins changed level, inputs did not
        intChk(1'b0);
        flip();
        intChk(1'b1);
        flip();
        intChk(1'b0);
        flip();
        intChk(1'b1);
        xfer(5'h08, 16'h0000);
        rd(HREG_RX, rx);
        chk({8'h00, rx[7:0]}, 16'h00d6);
        intChk(1'b0);
        flip();
        intChk(1'b1);
        // read port 1 then its partner port 0
        xfer(5'h19, 16'h0000);
        rd(HREG_RX, rx);
        chk(rx, 16'hc635);
        intChk(1'b0);
        xfer(5'h04, 16'h00f0);
        intChk(1'b1);
        xfer(5'h08, 16'h0000);
        rd(HREG_RX, rx);
        chk({8'h00, rx[7:0]}, 16'h0036);
        intChk(1'b0);
        test_done();
    end
endmodule
